// ===== hdl/mmd_regs.vh
`ifndef MMD_REGS_VH
`define MMD_REGS_VH

// Management register port
`define MMD_REG_AW          5
`define MMD_DW              16
`define MMD_ACC_CTRL_ADDR   5'h0D
`define MMD_ADDR_DATA_ADDR  5'h0E
`define MMD_STRAP_STAT_ADDR 5'h1E
`define MMD_SOFT_RST_ADDR   5'h1F
`define MMD_SOFT_RST_BIT    15
`define MMD_RD_ZERO         16'h0000

// Access-control fields
`define MMD_FUNC_MSB        15
`define MMD_FUNC_LSB        14
`define MMD_DEV_MSB         4
`define MMD_DEV_LSB         0
`define MMD_FUNC_W          2
`define MMD_DEV_W           5
`define MMD_FUNC_ADDR       2'h0
`define MMD_FUNC_DATA       2'h1
`define MMD_FUNC_INC_ALL    2'h2
`define MMD_FUNC_INC_WR     2'h3
`define MMD_DEV_VENDOR      5'h1F
`define MMD_DEV_PMA         5'h01
`define MMD_FUNC_RST        2'h0
`define MMD_DEV_RST         5'h00

// Extended spaces
`define MMD_NUM_SPACE       2
`define MMD_DEPTH           32
`define MMD_IDX_MSB         4
`define MMD_ADDR_RST        16'h0000
`define MMD_ADDR_INC        16'h0001

// Straps
`define MMD_NUM_STRAP       4
`define MMD_STRAP_LVL_W     2
`define MMD_STRAP_W         8
`define MMD_STRAP_RST       8'h00

// Strap level codes and the mode value each one selects
`define MMD_LVL_1           2'h0
`define MMD_LVL_2           2'h1
`define MMD_LVL_3           2'h2
`define MMD_MODE_1          2'h0
`define MMD_MODE_2          2'h1
`define MMD_MODE_3          2'h2
`define MMD_MODE_4          2'h3

`endif

// ===== hdl/mmd_indirect_access.v
// Summary of operation
// R1: Control write 0x1F selects address function, vendor space; next data write loads address.
// R2: Control write 0x1 selects address function, PMA space; next data write loads address.
// R3: Under address function every data-register write overwrites that space's address.
// R4: Under address function data-register reads return the space's address register.
// R5: Control 0x401F gives plain data access to addressed vendor register.
// R6: Control 0x4001 gives plain data access to addressed PMA register.
// R7: No-increment writes keep hitting the same register; address stays.
// R8: No-increment reads keep returning the same register; address stays.
// R9: Function 10 write stores data then increments the address.
// R10: Function 10 read returns data then increments the address.
// R11: Control 0xC01F selects increment on writes only, vendor space.
// R12: PMA space accepts 0x8001 and 0xC001 with same increment behaviour.
// R13: Software may skip address setup when address already correct.
// R14: Straps sampled after power-up, reset pin, and register-initiated reset.
// R15: Each strap decodes one of four levels into its own mode value.
// R16: Control bits 15:14 hold function, bits 4:0 hold device address.
// R17: Function 11 read returns data and leaves the address unchanged.
// R18: Data-register accesses with unsupported device address are ignored.
// R19: Access control at address 0xD, address/data at address 0xE.
// R20: Separate 16-bit address per space; increment wraps past top to zero.
`timescale 1ns/1ps
`default_nettype none
`include "mmd_regs.vh"

// Register map on the port
//   0x0D access control: function in 15:14, device space in 4:0
//   0x0E address/data window into the selected space
//   0x1E strap status: latched modes in 7:0, read only
//   0x1F soft reset: bit 15 set clears selection and resamples straps
//   Every other address reads zero and drops writes
//   Read data shows only in the cycle after the read strobe

// Notes for users
//   Storage words are not reset and read as unknown until written
//   Only 32 words per space are kept; higher addresses alias onto them
//   Accesses with an unsupported space neither store nor move an address
//   The increment wraps from 0xFFFF to zero in each space separately
//   Strap modes change only when hard reset clears them and at the load that follows either reset
//   Straps must be steady at the first clock after reset release
//   Soft reset clears both address registers as well as the selection
//   No access waits; every strobe is answered in one cycle

module mmd_indirect_access
(
  // Clock and reset
  input  wire                        clk,
  input  wire                        srst,
  // Register port
  input  wire [`MMD_REG_AW-1:0]      reg_addr,
  input  wire [`MMD_DW-1:0]          reg_wdata,
  input  wire                        reg_wr,
  input  wire                        reg_rd,
  output reg  [`MMD_DW-1:0]          reg_rdata,
  // Strap level codes from pin comparators, two bits per strap
  input  wire [`MMD_STRAP_W-1:0]     strap_level,
  // Latched strap modes
  output reg  [`MMD_STRAP_W-1:0]     strap_mode
);

  // Access-control register fields
  reg  [`MMD_FUNC_W-1:0]             func_q;
  reg  [`MMD_DEV_W-1:0]              dev_q;

  // Strap capture
  reg  [`MMD_STRAP_W-1:0]            strap_meta_q;
  reg  [`MMD_STRAP_W-1:0]            strap_sync_q;
  wire [`MMD_STRAP_W-1:0]            strap_dec;

  // Strobe decode
  wire                               wr_ctrl;
  wire                               wr_data;
  wire                               rd_data;
  wire                               soft_rst;

  // Function decode
  wire                               addr_func;
  wire                               inc_on_wr;
  wire                               inc_on_rd;

  // Per-space results, packed one word per space
  wire [`MMD_NUM_SPACE*`MMD_DW-1:0]  sp_rdata;
  wire [`MMD_NUM_SPACE-1:0]          sp_hit;

  // Read path
  reg  [`MMD_DW-1:0]                 rdata_d;
  reg  [`MMD_DW-1:0]                 data_rd;

  assign wr_ctrl   = reg_wr && (reg_addr == `MMD_ACC_CTRL_ADDR);    // R19
  assign wr_data   = reg_wr && (reg_addr == `MMD_ADDR_DATA_ADDR);   // R19
  assign rd_data   = reg_rd && (reg_addr == `MMD_ADDR_DATA_ADDR);

  // Soft reset is a strobe, not a stored bit; it reads back as zero
  assign soft_rst  = reg_wr && (reg_addr == `MMD_SOFT_RST_ADDR)
                     && reg_wdata[`MMD_SOFT_RST_BIT];

  // Function 00 turns the data window into the address register
  assign addr_func = (func_q == `MMD_FUNC_ADDR);
  // Increment policy by function field
  assign inc_on_wr = (func_q == `MMD_FUNC_INC_ALL)
                     || (func_q == `MMD_FUNC_INC_WR);                // R9 R11 R12
  assign inc_on_rd = (func_q == `MMD_FUNC_INC_ALL);                 // R10 R17

  // Access-control register; other bits are not stored and read as zero
  // Soft reset clears the selection, so software must set it up again
  always @(posedge clk)
  begin
    if (srst || soft_rst)
    begin
      func_q <= `MMD_FUNC_RST;
      dev_q  <= `MMD_DEV_RST;
    end
    else if (wr_ctrl)
    begin
      func_q <= reg_wdata[`MMD_FUNC_MSB:`MMD_FUNC_LSB];             // R16 R1 R2 R5 R6
      dev_q  <= reg_wdata[`MMD_DEV_MSB:`MMD_DEV_LSB];               // R16
    end
  end

  // One address register and one register array per extended space
  // Address keeps all 16 bits so readback shows exactly what was written
  // Spaces never share state; switching space keeps the other's address
  genvar s;
  generate
    for (s = 0; s < `MMD_NUM_SPACE; s = s + 1)
    begin : g_space
      reg  [`MMD_DW-1:0] addr_q;
      reg  [`MMD_DW-1:0] mem [0:`MMD_DEPTH-1];
      wire [`MMD_DEV_W-1:0] code;
      wire               hit;
      wire               do_wr;
      wire               do_rd;
      wire               bump;

      // Vendor space first, PMA space second
      assign code  = (s == 0) ? `MMD_DEV_VENDOR : `MMD_DEV_PMA;
      // Other device addresses match no space, so accesses fall away
      assign hit   = (dev_q == code);                                // R18
      assign do_wr = wr_data && hit;
      assign do_rd = rd_data && hit;
      assign bump  = !addr_func
                     && ((do_wr && inc_on_wr) || (do_rd && inc_on_rd));
      assign sp_hit[s] = hit;
      assign sp_rdata[s*`MMD_DW +: `MMD_DW] =
        addr_func ? addr_q : mem[addr_q[`MMD_IDX_MSB:0]];          // R4 R8

      // Address register: load in address function, bump after access
      always @(posedge clk)
      begin
        if (srst || soft_rst)
          addr_q <= `MMD_ADDR_RST;
        else if (do_wr && addr_func)
          addr_q <= reg_wdata;                                       // R1 R2 R3
        else if (bump)
          addr_q <= addr_q + `MMD_ADDR_INC;                          // R20 R9 R10
      end

      // Storage is not reset; only the low index bits select a word
      always @(posedge clk)
      begin
        if (do_wr && !addr_func)
          mem[addr_q[`MMD_IDX_MSB:0]] <= reg_wdata;                  // R5 R6 R7
      end
    end
  endgenerate

  // Data path value of whichever space is addressed
  // At most one space matches, so the priority order never matters
  always @*
  begin
    data_rd = `MMD_RD_ZERO;
    if (sp_hit[0])
      data_rd = sp_rdata[0 +: `MMD_DW];
    else if (sp_hit[1])
      data_rd = sp_rdata[`MMD_DW +: `MMD_DW];
  end

  // Read mux; unmapped addresses answer zero
  // Decoded from the strobe cycle's address, registered below
  always @*
  begin
    rdata_d = `MMD_RD_ZERO;
    case (reg_addr)
      `MMD_ACC_CTRL_ADDR:
      begin
        rdata_d[`MMD_FUNC_MSB:`MMD_FUNC_LSB] = func_q;
        rdata_d[`MMD_DEV_MSB:`MMD_DEV_LSB]   = dev_q;
      end
      `MMD_ADDR_DATA_ADDR:
        rdata_d = data_rd;                                           // R18
      `MMD_STRAP_STAT_ADDR:
        rdata_d[`MMD_STRAP_W-1:0] = strap_mode;
      default:
        rdata_d = `MMD_RD_ZERO;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  // Zero outside that cycle keeps stale data off the port
  always @(posedge clk)
  begin
    if (srst)
      reg_rdata <= `MMD_RD_ZERO;
    else if (reg_rd)
      reg_rdata <= rdata_d;
    else
      reg_rdata <= `MMD_RD_ZERO;
  end

  // Strap pins are asynchronous; two flops before any use
  // Reset clears both stages so no stale level is latched
  always @(posedge clk)
  begin
    if (srst)
    begin
      strap_meta_q <= `MMD_STRAP_RST;
      strap_sync_q <= `MMD_STRAP_RST;
    end
    else
    begin
      strap_meta_q <= strap_level;
      strap_sync_q <= strap_meta_q;
    end
  end

  // Four-level decode per strap: each level gives its own mode value
  // Identity table today; another mapping needs only this case
  genvar p;
  generate
    for (p = 0; p < `MMD_NUM_STRAP; p = p + 1)
    begin : g_strap
      reg  [`MMD_STRAP_LVL_W-1:0] mode;

      // Comparator code to mode; every code has a defined mode
      always @*
      begin
        case (strap_sync_q[p*`MMD_STRAP_LVL_W +: `MMD_STRAP_LVL_W])
          `MMD_LVL_1: mode = `MMD_MODE_1;                            // R15
          `MMD_LVL_2: mode = `MMD_MODE_2;                            // R15
          `MMD_LVL_3: mode = `MMD_MODE_3;                            // R15
          default:    mode = `MMD_MODE_4;                            // R15
        endcase
      end

      // One driver per slice of the decoded word
      assign strap_dec[p*`MMD_STRAP_LVL_W +: `MMD_STRAP_LVL_W] = mode;
    end
  endgenerate

  // Sampler states: two clocks to fill the synchroniser, then one load
  localparam [1:0] SMP_DONE  = 2'b00;
  localparam [1:0] SMP_FILL1 = 2'b01;
  localparam [1:0] SMP_FILL2 = 2'b10;
  localparam [1:0] SMP_LOAD  = 2'b11;

  reg  [1:0]                         smp_q;
  reg  [1:0]                         smp_d;

  // Next state; the load happens once, then the mode stands
  always @*
  begin
    smp_d = smp_q;
    case (smp_q)
      SMP_FILL1: smp_d = SMP_FILL2;
      SMP_FILL2: smp_d = SMP_LOAD;
      SMP_LOAD:  smp_d = SMP_DONE;
      SMP_DONE:  smp_d = SMP_DONE;
      default:   smp_d = SMP_DONE;
    endcase
  end

  // Either reset restarts sampling; a held reset keeps it waiting
  // Soft reset leaves the sync flops running, so their levels count
  always @(posedge clk)
  begin
    if (srst || soft_rst)
      smp_q <= SMP_FILL1;                                            // R14
    else
      smp_q <= smp_d;
  end

  // Latch modes once the pin levels have passed both flops
  // After soft reset old modes stand until the new ones load; hard reset clears them to zero
  always @(posedge clk)
  begin
    if (srst)
      strap_mode <= `MMD_STRAP_RST;
    else if (smp_q == SMP_LOAD)
      strap_mode <= strap_dec;                                       // R14
  end

endmodule // mmd_indirect_access

`default_nettype wire

// ===== testbench/mmd_sta_model.sv
`timescale 1ns/1ps
`default_nettype none
// Management entity: one strobe per access, moved just after the rising edge
module mmd_sta_model
(
  // Clock
  input  wire logic        clk,
  // Register port
  output var  logic [4:0]  reg_addr,
  output var  logic [15:0] reg_wdata,
  output var  logic        reg_wr,
  output var  logic        reg_rd,
  input  wire logic [15:0] reg_rdata
);
  // Idle bus from time zero
  initial
  begin
    reg_addr = 5'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // One write; stale data is inverted so it never looks valid
  task wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;
  endtask
  // One read; data stands only in the cycle after the strobe
  task rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
endmodule // mmd_sta_model
`default_nettype wire

// ===== testbench/mmd_checker_sva.sv
`timescale 1ns/1ps
`default_nettype none
module mmd_checker
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        srst,
  // Register port and straps
  input wire logic [4:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic [7:0]  strap_level,
  input wire logic [7:0]  strap_mode
);
  logic [1:0]  fn_q;
  logic [4:0]  dv_q;
  logic [15:0] va_q;
  logic [15:0] pa_q;
  logic [3:0]  age_q;
  wire         ok  = (dv_q == 5'h1F) || (dv_q == 5'h01);
  wire         hit = ok && reg_addr == 5'h0E && (reg_wr || reg_rd);
  wire         sft = reg_wr && reg_addr == 5'h1F && reg_wdata[15];
  wire         ld  = fn_q == 2'h0 && reg_wr;
  wire         upd = hit && (ld || fn_q == 2'h2 || (fn_q == 2'h3 && reg_wr));
  wire [15:0]  cur = dv_q[4] ? va_q : pa_q;
  wire [15:0]  nxt = ld ? reg_wdata : cur + 16'h0001;
  // Shadow of control and both address registers to predict read data
  always @(posedge clk)
  begin
    if (srst || sft)
    begin
      fn_q  <= 2'h0;
      dv_q  <= 5'h00;
      va_q  <= 16'h0000;
      pa_q  <= 16'h0000;
      age_q <= 4'h0;
    end
    else
    begin
      if (reg_wr && reg_addr == 5'h0D)
      begin
        fn_q <= reg_wdata[15:14];
        dv_q <= reg_wdata[4:0];
      end
      if (upd && dv_q[4])
        va_q <= nxt;
      if (upd && !dv_q[4])
        pa_q <= nxt;
      if (age_q != 4'hF)
        age_q <= age_q + 4'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside answer cycle");
  a_ctl_readback: assert property (reg_rd && reg_addr == 5'h0D |=> reg_rdata == {fn_q, 9'h000, dv_q})
    else $error("control readback wrong");
  a_addr_readback: assert property (reg_rd && reg_addr == 5'h0E && ok && fn_q == 2'h0 |=> reg_rdata == cur)
    else $error("address readback wrong");
  a_bad_dev: assert property (reg_rd && reg_addr == 5'h0E && !ok |=> reg_rdata == 16'h0000)
    else $error("unsupported space not ignored");
  a_unmapped_zero: assert property (reg_rd && !(reg_addr inside {5'h0D, 5'h0E, 5'h1E}) |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_strap_stat: assert property ($past(reg_rd && reg_addr == 5'h1E) |-> reg_rdata == {8'h00, $past(strap_mode)})
    else $error("strap status wrong");
  a_strap_load: assert property (age_q == 4'h1 |-> ##[0:4] strap_mode == strap_level)
    else $error("straps not sampled after reset");
  a_strap_hold: assert property (!$stable(strap_mode) |-> age_q < 4'h8)
    else $error("strap mode changed outside sampling");
  c_inc_read: cover property (reg_rd && hit && fn_q == 2'h2);
  c_soft_rst: cover property (sft);
  c_bad_dev: cover property (reg_rd && reg_addr == 5'h0E && !ok);
endmodule // mmd_checker
bind mmd_indirect_access mmd_checker chk (.clk(clk), .srst(srst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .strap_level(strap_level), .strap_mode(strap_mode));
`default_nettype wire

// ===== testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
  begin \
    tests_run++; \
    if ((g) !== (e)) \
    begin \
      fails++; \
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); \
    end \
  end
module tb_top;
  logic        clk;
  logic        srst;
  logic [4:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic [7:0]  strap_level;
  logic [7:0]  strap_mode;
  int          fails = 0;
  int          tests_run = 0;
  // 125 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  mmd_indirect_access uut (.clk(clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .strap_level(strap_level), .strap_mode(strap_mode));
  mmd_sta_model sta (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  // Read one register and compare
  task rc(input logic [4:0] a, input logic [15:0] e);
    logic [15:0] d;
    sta.rd(a, d);
    `CHK(d, e)
  endtask
  task w(input logic [4:0] a, input logic [15:0] d);
    sta.wr(a, d);
  endtask
  task stop_test;
    $display("Counts: %0d mismatches, %0d checks", fails, tests_run);
    if (fails == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Hang guard
  initial
  begin
    repeat (5000) @(posedge clk);
    fails++;
    stop_test();
  end
  // Main sequence; straps span all four level codes
  initial
  begin
    srst = 1'b1;
    strap_level = 8'hE4;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    repeat (5) @(posedge clk);
    rc(5'h1E, 16'h00E4);
    w(5'h0D, 16'h001F);
    w(5'h0E, 16'h0005);
    rc(5'h0E, 16'h0005);
    w(5'h0E, 16'h0003);
    rc(5'h0E, 16'h0003);
    w(5'h0D, 16'h801F);
    w(5'h0E, 16'h00A0);
    w(5'h0E, 16'h00A1);
    w(5'h0D, 16'h001F);
    rc(5'h0E, 16'h0005);
    w(5'h0E, 16'h0003);
    w(5'h0D, 16'h801F);
    rc(5'h0E, 16'h00A0);
    rc(5'h0E, 16'h00A1);
    w(5'h0D, 16'h001F);
    rc(5'h0E, 16'h0005);
    w(5'h0E, 16'h0003);
    w(5'h0D, 16'h401F);
    w(5'h0E, 16'h1234);
    w(5'h0E, 16'h5678);
    rc(5'h0E, 16'h5678);
    rc(5'h0E, 16'h5678);
    w(5'h0D, 16'hC01F);
    rc(5'h0E, 16'h5678);
    w(5'h0E, 16'h00B0);
    rc(5'h0E, 16'h00A1);
    w(5'h0D, 16'h0001);
    w(5'h0E, 16'h0004);
    w(5'h0D, 16'h4001);
    w(5'h0E, 16'h00C4);
    w(5'h0D, 16'h8001);
    rc(5'h0E, 16'h00C4);
    w(5'h0D, 16'hC001);
    w(5'h0E, 16'h00C5);
    w(5'h0D, 16'h0001);
    rc(5'h0E, 16'h0006);
    w(5'h0D, 16'h001F);
    rc(5'h0E, 16'h0004);
    w(5'h0E, 16'hFFFF);
    w(5'h0D, 16'hC01F);
    w(5'h0E, 16'h0077);
    w(5'h0D, 16'h001F);
    rc(5'h0E, 16'h0000);
    w(5'h0D, 16'h0002);
    rc(5'h0E, 16'h0000);
    w(5'h0E, 16'h1111);
    rc(5'h0D, 16'h0002);
    w(5'h0D, 16'h001F);
    rc(5'h0E, 16'h0000);
    w(5'h0D, 16'hFFFF);
    rc(5'h0D, 16'hC01F);
    rc(5'h05, 16'h0000);
    @(posedge clk);
    strap_level <= 8'h1B;
    w(5'h1F, 16'h8000);
    repeat (6) @(posedge clk);
    rc(5'h1E, 16'h001B);
    rc(5'h0D, 16'h0000);
    @(posedge clk);
    strap_level <= 8'h4E;
    srst <= 1'b1;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    repeat (5) @(posedge clk);
    rc(5'h1E, 16'h004E);
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
